// ===== inc/mbx_pkg.sv
// mbx_pkg: shared types and constants of the branch/misc/arith execution unit
// assumes: one system clock; the instruction arrives already decoded
package mbx_pkg;

  // ----------------------------------------
  // instruction set handled by this unit
  // ----------------------------------------
  typedef enum logic [5:0] {
    MBX_NO_OPERATION,
    MBX_JUMP_DIRECT,
    MBX_SKIP_IF_ZERO,
    MBX_SKIP_ZERO_COPY_ACC,
    MBX_SKIP_BIT_CLEAR,
    MBX_SKIP_BIT_SET,
    MBX_SKIP_INCREMENTED_ZERO,
    MBX_SKIP_DECREMENTED_ZERO,
    MBX_SKIP_INCREMENTED_ZERO_TO_ACC,
    MBX_SKIP_DECREMENTED_ZERO_TO_ACC,
    MBX_CALL,
    MBX_SUBROUTINE_EXIT,
    MBX_SUBROUTINE_EXIT_LOAD_ACC,
    MBX_INTERRUPT_EXIT,
    MBX_TABLE_FETCH_CURRENT_PAGE,
    MBX_TABLE_FETCH_LAST_PAGE,
    MBX_CLEAR_BYTE,
    MBX_SET_BYTE,
    MBX_CLEAR_BIT,
    MBX_WATCHDOG_CLEAR,
    MBX_WATCHDOG_PRECLEAR_FIRST,
    MBX_WATCHDOG_PRECLEAR_SECOND,
    MBX_NIBBLE_EXCHANGE,
    MBX_NIBBLE_EXCHANGE_TO_ACC,
    MBX_ADD_WITH_CARRY,
    MBX_ADD_WITH_CARRY_TO_MEMORY,
    MBX_ADD,
    MBX_ADD_TO_MEMORY,
    MBX_ADD_IMMEDIATE,
    MBX_BITWISE_AND,
    MBX_BITWISE_AND_TO_MEMORY,
    MBX_BITWISE_AND_IMMEDIATE,
    MBX_HALT
  } mbx_op_e;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int MBX_PC_W = 11;
  localparam int MBX_ROM_W = 14;
  localparam int MBX_STACK_DEPTH = 6;
  localparam int MBX_CLKS_PER_CYCLE = 4;
  localparam logic [1:0] MBX_PHASE_LAST = 2'h3;
  localparam logic [1:0] MBX_CYC_ONE = 2'h1;
  localparam logic [1:0] MBX_CYC_TWO = 2'h2;
  localparam logic [7:0] MBX_BYTE_ZERO = 8'h00;
  localparam logic [7:0] MBX_BYTE_ONES = 8'hff;
  localparam logic [7:0] MBX_WDT_RESET = 8'h00;
  localparam logic [7:0] MBX_NIBBLE_MAX = 8'h0f;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    mbx_op_e op;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [MBX_PC_W-1:0] addr;
    logic dst_is_pcl;
  } mbx_instr_s;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } mbx_flags_s;

  typedef struct packed {
    logic mem_we;
    logic [7:0] mem_wdata;
    logic acc_we;
    logic [7:0] acc_wdata;
    logic tbl_we;
    logic [MBX_ROM_W-9:0] tbl_wdata;
  } mbx_wr_s;

endpackage

// ===== design/mbx_alu.sv
// mbx_alu: combinational add / and / bit-test datapath
// assumes: operands valid for the whole execute cycle
`timescale 1ns/1ns
`default_nettype none
module mbx_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic [2:0] bit_sel,
  output logic [7:0] sum,
  output mbx_pkg::mbx_flags_s add_flags,
  output logic [7:0] and_res,
  output logic [7:0] inc_res,
  output logic [7:0] dec_res,
  output logic bit_val
);
  logic [4:0] lo;
  logic [8:0] full;
  always_comb begin
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    sum = full[7:0];
    add_flags.c = full[8];
    add_flags.ac = lo[4];
    add_flags.z = (full[7:0] == mbx_pkg::MBX_BYTE_ZERO);
    add_flags.ov = (a[7] == b[7]) && (full[7] != a[7]);
    and_res = a & b;
    inc_res = b + 8'h01;
    dec_res = b - 8'h01;
    bit_val = b[bit_sel];
  end
endmodule
`default_nettype wire

// ===== design/mbx_exec.sv
// mbx_exec: execute stage for branch, skip, call, table, watchdog, misc and add/and
// assumes: decoded instruction held stable while instr_valid and instr_ready both high
// Operation
// - skip-if-zero skips next instruction when memory byte is zero
// - copy variant also loads byte into accumulator, skip on zero
// - bit-test skips on selected bit clear or set, index 0 to 7
// - memory increment/decrement writes back, skips on zero, both penalties
// - accumulator increment/decrement keeps memory, skip penalty only
// - call pushes next address, loads target, two cycles
// - returns pop counter in two cycles; one variant loads accumulator
// - table read puts low byte in memory, upper in table high, two cycles
// - watchdog clear zeroes counter, clears power-down and time-out flags
// - preclear pair clears watchdog only after both executed
// - writing program counter low adds one instruction cycle
// - a taken skip adds one instruction cycle
// - clear-byte writes zero, one cycle plus counter-low penalty
// - clear-bit zeroes one selected bit, others untouched
// - nibble exchange swaps halves to memory or accumulator
// - add-with-carry sums accumulator, memory, carry; four flags updated
// - plain add of memory or immediate updates four flags
// - bitwise and updates only zero flag
// - jump loads program counter from instruction address
// - interrupt return pops counter and sets global interrupt enable
// - halt stops execution, clears watchdog, sets power-down, clears time-out
`timescale 1ns/1ns
`default_nettype none
module mbx_exec #(
  parameter int PC_W = mbx_pkg::MBX_PC_W,
  parameter int STACK_DEPTH = mbx_pkg::MBX_STACK_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire mbx_pkg::mbx_instr_s instr,
  input wire logic [7:0] mem_rdata,
  input wire logic [mbx_pkg::MBX_ROM_W-1:0] rom_rdata,
  input wire logic wake,
  output logic [PC_W-1:0] rom_addr,
  output logic [PC_W-1:0] pc,
  output logic [7:0] acc,
  output mbx_pkg::mbx_flags_s flags,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic global_int_en,
  output logic wdt_clear,
  output logic halted,
  output logic skip_next,
  output mbx_pkg::mbx_wr_s wr,
  output logic [7:0] table_high_byte,
  output logic stack_overflow,
  input wire logic watchdog_timeout
);
  if (PC_W < 9 || PC_W > 16 || STACK_DEPTH < 1 || STACK_DEPTH > 16) begin : g_param_check
    $error("mbx_exec: unsupported parameter");
  end

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  logic [7:0] sum;
  mbx_pkg::mbx_flags_s add_flags;
  logic [7:0] and_res;
  logic [7:0] inc_res;
  logic [7:0] dec_res;
  logic bit_val;
  logic [7:0] alu_b;
  logic alu_cin;

  always_comb begin
    alu_b = (instr.op == mbx_pkg::MBX_ADD_IMMEDIATE || instr.op == mbx_pkg::MBX_BITWISE_AND_IMMEDIATE)
            ? instr.imm : mem_rdata;
    alu_cin = (instr.op == mbx_pkg::MBX_ADD_WITH_CARRY || instr.op == mbx_pkg::MBX_ADD_WITH_CARRY_TO_MEMORY)
              ? flags.c : 1'b0;
  end

  mbx_alu u_alu (
    .a(acc),
    .b(alu_b),
    .cin(alu_cin),
    .bit_sel(instr.bit_sel),
    .sum(sum),
    .add_flags(add_flags),
    .and_res(and_res),
    .inc_res(inc_res),
    .dec_res(dec_res),
    .bit_val(bit_val)
  );

  // ----------------------------------------
  // phase timing: 4 clocks per instruction cycle
  // ----------------------------------------
  logic [1:0] phase_q, phase_d;
  logic [1:0] cyc_q, cyc_d;
  logic busy_q, busy_d;
  logic cycle_end;
  logic [1:0] cyc_need;
  logic skip_taken;
  logic pcl_pen;

  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  mbx_pkg::mbx_flags_s flags_q, flags_d;
  logic to_q, to_d;
  logic pdf_q, pdf_d;
  logic gie_q, gie_d;
  logic pre1_q, pre1_d;
  logic pre2_q, pre2_d;
  logic halt_q, halt_d;
  logic [7:0] table_high_byte_q, table_high_byte_d;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [PC_W-1:0] stack_d [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH+1)-1:0] sp_q, sp_d;
  logic ovf_q, ovf_d;
  mbx_pkg::mbx_wr_s wr_q, wr_d;
  logic wdtc_q, wdtc_d;
  logic skip_q, skip_d;
  logic take;
  logic pop_top;

  assign take = instr_valid && !busy_q && !halt_q;
  assign instr_ready = !busy_q && !halt_q;
  assign cycle_end = (phase_q == mbx_pkg::MBX_PHASE_LAST);

  always_comb begin
    skip_taken = 1'b0;
    case (instr.op)
      mbx_pkg::MBX_SKIP_IF_ZERO: skip_taken = (mem_rdata == mbx_pkg::MBX_BYTE_ZERO);
      mbx_pkg::MBX_SKIP_ZERO_COPY_ACC: skip_taken = (mem_rdata == mbx_pkg::MBX_BYTE_ZERO);
      mbx_pkg::MBX_SKIP_BIT_CLEAR: skip_taken = !bit_val;
      mbx_pkg::MBX_SKIP_BIT_SET: skip_taken = bit_val;
      mbx_pkg::MBX_SKIP_INCREMENTED_ZERO,
      mbx_pkg::MBX_SKIP_INCREMENTED_ZERO_TO_ACC: skip_taken = (inc_res == mbx_pkg::MBX_BYTE_ZERO);
      mbx_pkg::MBX_SKIP_DECREMENTED_ZERO,
      mbx_pkg::MBX_SKIP_DECREMENTED_ZERO_TO_ACC: skip_taken = (dec_res == mbx_pkg::MBX_BYTE_ZERO);
      default: skip_taken = 1'b0;
    endcase
  end

  // memory-destination forms that take the program-counter-low penalty
  always_comb begin
    case (instr.op)
      mbx_pkg::MBX_SKIP_INCREMENTED_ZERO, mbx_pkg::MBX_SKIP_DECREMENTED_ZERO,
      mbx_pkg::MBX_TABLE_FETCH_CURRENT_PAGE, mbx_pkg::MBX_TABLE_FETCH_LAST_PAGE,
      mbx_pkg::MBX_CLEAR_BYTE, mbx_pkg::MBX_SET_BYTE, mbx_pkg::MBX_CLEAR_BIT,
      mbx_pkg::MBX_NIBBLE_EXCHANGE, mbx_pkg::MBX_ADD_WITH_CARRY_TO_MEMORY,
      mbx_pkg::MBX_ADD_TO_MEMORY, mbx_pkg::MBX_BITWISE_AND_TO_MEMORY: pcl_pen = instr.dst_is_pcl;
      default: pcl_pen = 1'b0;
    endcase
  end

  always_comb begin
    case (instr.op)
      mbx_pkg::MBX_JUMP_DIRECT, mbx_pkg::MBX_CALL, mbx_pkg::MBX_SUBROUTINE_EXIT,
      mbx_pkg::MBX_SUBROUTINE_EXIT_LOAD_ACC, mbx_pkg::MBX_INTERRUPT_EXIT,
      mbx_pkg::MBX_TABLE_FETCH_CURRENT_PAGE, mbx_pkg::MBX_TABLE_FETCH_LAST_PAGE: cyc_need = mbx_pkg::MBX_CYC_TWO;
      default: cyc_need = mbx_pkg::MBX_CYC_ONE;
    endcase
    cyc_need = cyc_need + {1'b0, pcl_pen} + {1'b0, skip_taken};
  end

  always_comb begin
    phase_d = phase_q;
    cyc_d = cyc_q;
    busy_d = busy_q;
    if (take) begin
      busy_d = 1'b1;
      phase_d = 2'h0;
      cyc_d = cyc_need;
    end else if (busy_q) begin
      phase_d = phase_q + 2'h1;
      if (cycle_end) begin
        cyc_d = cyc_q - 2'h1;
        if (cyc_q == mbx_pkg::MBX_CYC_ONE) begin
          busy_d = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // instruction effects, applied at the take edge
  // ----------------------------------------
  assign pop_top = (sp_q != '0);
  always_comb begin
    pc_d = pc_q;
    acc_d = acc_q;
    flags_d = flags_q;
    to_d = to_q;
    pdf_d = pdf_q;
    gie_d = gie_q;
    pre1_d = pre1_q;
    pre2_d = pre2_q;
    halt_d = halt_q && !wake;
    table_high_byte_d = table_high_byte_q;
    stack_d = stack_q;
    sp_d = sp_q;
    ovf_d = ovf_q;
    wr_d = '0;
    wdtc_d = 1'b0;
    skip_d = 1'b0;
    if (take) begin
      pc_d = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
      skip_d = skip_taken;
      if (skip_taken) begin
        pc_d = pc_q + {{(PC_W-2){1'b0}}, 2'h2};
      end
      case (instr.op)
        mbx_pkg::MBX_JUMP_DIRECT: pc_d = instr.addr;
        mbx_pkg::MBX_SKIP_ZERO_COPY_ACC: acc_d = mem_rdata;
        mbx_pkg::MBX_SKIP_INCREMENTED_ZERO: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = inc_res;
        end
        mbx_pkg::MBX_SKIP_DECREMENTED_ZERO: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = dec_res;
        end
        mbx_pkg::MBX_SKIP_INCREMENTED_ZERO_TO_ACC: acc_d = inc_res;
        mbx_pkg::MBX_SKIP_DECREMENTED_ZERO_TO_ACC: acc_d = dec_res;
        mbx_pkg::MBX_CALL: begin
          if (sp_q == STACK_DEPTH[$bits(sp_q)-1:0]) begin
            ovf_d = 1'b1;
          end else begin
            stack_d[sp_q] = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
            sp_d = sp_q + 1'b1;
          end
          pc_d = instr.addr;
        end
        mbx_pkg::MBX_SUBROUTINE_EXIT, mbx_pkg::MBX_SUBROUTINE_EXIT_LOAD_ACC,
        mbx_pkg::MBX_INTERRUPT_EXIT: begin
          if (pop_top) begin
            pc_d = stack_q[sp_q - 1'b1];
            sp_d = sp_q - 1'b1;
          end
          if (instr.op == mbx_pkg::MBX_SUBROUTINE_EXIT_LOAD_ACC) begin
            acc_d = instr.imm;
          end
          if (instr.op == mbx_pkg::MBX_INTERRUPT_EXIT) begin
            gie_d = 1'b1;
          end
        end
        mbx_pkg::MBX_TABLE_FETCH_CURRENT_PAGE, mbx_pkg::MBX_TABLE_FETCH_LAST_PAGE: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = rom_rdata[7:0];
          wr_d.tbl_we = 1'b1;
          wr_d.tbl_wdata = rom_rdata[mbx_pkg::MBX_ROM_W-1:8];
          table_high_byte_d = {2'h0, rom_rdata[mbx_pkg::MBX_ROM_W-1:8]};
        end
        mbx_pkg::MBX_CLEAR_BYTE: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = mbx_pkg::MBX_BYTE_ZERO;
        end
        mbx_pkg::MBX_SET_BYTE: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = mbx_pkg::MBX_BYTE_ONES;
        end
        mbx_pkg::MBX_CLEAR_BIT: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = mem_rdata & ~(8'h01 << instr.bit_sel);
        end
        mbx_pkg::MBX_WATCHDOG_CLEAR: begin
          wdtc_d = 1'b1;
          to_d = 1'b0;
          pdf_d = 1'b0;
          pre1_d = 1'b0;
          pre2_d = 1'b0;
        end
        mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST, mbx_pkg::MBX_WATCHDOG_PRECLEAR_SECOND: begin
          if ((instr.op == mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST) ? pre2_q : pre1_q) begin
            wdtc_d = 1'b1;
            to_d = 1'b0;
            pdf_d = 1'b0;
            pre1_d = 1'b0;
            pre2_d = 1'b0;
          end else if (instr.op == mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST) begin
            pre1_d = 1'b1;
          end else begin
            pre2_d = 1'b1;
          end
        end
        mbx_pkg::MBX_NIBBLE_EXCHANGE: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = {mem_rdata[3:0], mem_rdata[7:4]};
        end
        mbx_pkg::MBX_NIBBLE_EXCHANGE_TO_ACC: acc_d = {mem_rdata[3:0], mem_rdata[7:4]};
        mbx_pkg::MBX_ADD_WITH_CARRY, mbx_pkg::MBX_ADD, mbx_pkg::MBX_ADD_IMMEDIATE: begin
          acc_d = sum;
          flags_d = add_flags;
        end
        mbx_pkg::MBX_ADD_WITH_CARRY_TO_MEMORY, mbx_pkg::MBX_ADD_TO_MEMORY: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = sum;
          flags_d = add_flags;
        end
        mbx_pkg::MBX_BITWISE_AND, mbx_pkg::MBX_BITWISE_AND_IMMEDIATE: begin
          acc_d = and_res;
          flags_d.z = (and_res == mbx_pkg::MBX_BYTE_ZERO);
        end
        mbx_pkg::MBX_BITWISE_AND_TO_MEMORY: begin
          wr_d.mem_we = 1'b1;
          wr_d.mem_wdata = and_res;
          flags_d.z = (and_res == mbx_pkg::MBX_BYTE_ZERO);
        end
        mbx_pkg::MBX_HALT: begin
          halt_d = 1'b1;
          wdtc_d = 1'b1;
          pdf_d = 1'b1;
          to_d = 1'b0;
        end
        default: pc_d = pc_d;
      endcase
    end
    // timeout set wins over a clear in the same cycle
    to_d = to_d || watchdog_timeout;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= 2'h0;
      cyc_q <= 2'h0;
      busy_q <= 1'b0;
      pc_q <= '0;
      acc_q <= mbx_pkg::MBX_BYTE_ZERO;
      flags_q <= '0;
      to_q <= 1'b0;
      pdf_q <= 1'b0;
      gie_q <= 1'b0;
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
      halt_q <= 1'b0;
      table_high_byte_q <= mbx_pkg::MBX_BYTE_ZERO;
      sp_q <= '0;
      ovf_q <= 1'b0;
      wr_q <= '0;
      wdtc_q <= 1'b0;
      skip_q <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= '0;
      end
    end else begin
      phase_q <= phase_d;
      cyc_q <= cyc_d;
      busy_q <= busy_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
      gie_q <= gie_d;
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
      halt_q <= halt_d;
      table_high_byte_q <= table_high_byte_d;
      sp_q <= sp_d;
      ovf_q <= ovf_d;
      wr_q <= wr_d;
      wdtc_q <= wdtc_d;
      skip_q <= skip_d;
      stack_q <= stack_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rom_addr = (instr.op == mbx_pkg::MBX_TABLE_FETCH_LAST_PAGE)
                    ? {{(PC_W-8){1'b1}}, acc_q} : {pc_q[PC_W-1:8], acc_q};
  assign pc = pc_q;
  assign acc = acc_q;
  assign flags = flags_q;
  assign timeout_flag = to_q;
  assign power_down_flag = pdf_q;
  assign global_int_en = gie_q;
  assign wdt_clear = wdtc_q;
  assign halted = halt_q;
  assign skip_next = skip_q;
  assign wr = wr_q;
  assign table_high_byte = table_high_byte_q;
  assign stack_overflow = ovf_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_skip_cost;
    @(posedge clk) disable iff (sys_rst)
    (take && skip_taken && !pcl_pen && instr.op != mbx_pkg::MBX_CALL) |=> busy_q [*8] ##1 !busy_q;
  endproperty
  a_skip_cost: assert property (p_skip_cost) else $error("taken skip not two cycles");
  property p_two_cycle;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_JUMP_DIRECT) |=> busy_q [*8] ##1 !busy_q;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("jump not two cycles");
  property p_one_cycle;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_NO_OPERATION) |=> busy_q [*4] ##1 !busy_q;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("no-op not one cycle");
  property p_wdt_clear;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_WATCHDOG_CLEAR && !watchdog_timeout) |=>
      wdt_clear && !timeout_flag && !power_down_flag;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear failed");
  property p_halt;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_HALT && !watchdog_timeout) |=>
      halted && power_down_flag && !timeout_flag && wdt_clear && !instr_ready;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_preclear_single;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST && !pre2_q) |=> !wdt_clear && pre1_q;
  endproperty
  a_preclear_single: assert property (p_preclear_single) else $error("single preclear acted");
  property p_call_push;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_CALL && sp_q == '0) |=> stack_q[0] == $past(pc_q) + 1'b1 && pc_q == $past(instr.addr);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");
  property p_clear_byte;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_CLEAR_BYTE) |=> wr.mem_we && wr.mem_wdata == 8'h00;
  endproperty
  a_clear_byte: assert property (p_clear_byte) else $error("clear byte wrong");
  property p_and_flags;
    @(posedge clk) disable iff (sys_rst)
    (take && instr.op == mbx_pkg::MBX_BITWISE_AND) |=> flags.c == $past(flags.c) && flags.ov == $past(flags.ov);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and touched carry or overflow");
endmodule
`default_nettype wire

// ===== dv/mbx_exec_tb.sv
// mbx_exec_tb: self-checking random bench for the execution unit
// assumes: mbx_pkg compiled first; results show one clock after take
`timescale 1ns/1ns
`default_nettype none
module mbx_exec_tb;
  localparam int PW = mbx_pkg::MBX_PC_W;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic instr_ready;
  mbx_pkg::mbx_instr_s instr = '0;
  logic [7:0] mem_rdata = 8'h00;
  logic [13:0] rom_rdata = 14'h0000;
  logic wake = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic [PW-1:0] rom_addr;
  logic [PW-1:0] pc;
  logic [7:0] acc;
  logic [7:0] table_high_byte;
  mbx_pkg::mbx_flags_s flags;
  mbx_pkg::mbx_wr_s wr;
  logic timeout_flag, power_down_flag, global_int_en, wdt_clear, halted, skip_next, stack_overflow;
  int bad_count = 0;
  int checks_done = 0;
  // ----------------------------------------
  // expected state
  // ----------------------------------------
  logic [PW-1:0] e_pc = '0;
  logic [7:0] e_acc = 8'h00;
  mbx_pkg::mbx_flags_s e_fl = '0;
  logic e_to = 1'b0;
  logic e_pdf = 1'b0;
  logic e_gie = 1'b0;
  logic pre1 = 1'b0;
  logic pre2 = 1'b0;
  logic pc_unk = 1'b0;
  logic [PW-1:0] stk[$];

  always #4 clk = ~clk;

  mbx_exec i_dut (
    .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr),
    .mem_rdata(mem_rdata), .rom_rdata(rom_rdata), .wake(wake), .rom_addr(rom_addr), .pc(pc), .acc(acc),
    .flags(flags), .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
    .global_int_en(global_int_en), .wdt_clear(wdt_clear), .halted(halted), .skip_next(skip_next), .wr(wr),
    .table_high_byte(table_high_byte), .stack_overflow(stack_overflow), .watchdog_timeout(watchdog_timeout)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // {ov, z, ac, c, sum}
  function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic exec(input mbx_pkg::mbx_op_e op, input logic [2:0] bs, input logic [7:0] im,
                      input logic [PW-1:0] ad, input logic pl, input logic [7:0] m, input logic [13:0] rw);
    int n;
    int en;
    logic sk, we, tw, wc, mf, ovf, pu, hl;
    logic [7:0] wd;
    logic [11:0] t;
    logic [PW-1:0] r, ra;
    {sk, we, tw, wc, mf, ovf, hl} = '0;
    wd = 8'h00;
    en = 1;
    pu = pc_unk;
    r = e_pc + 1'b1;
    ra = {e_pc[PW-1:8], e_acc};
    case (op)
      mbx_pkg::MBX_JUMP_DIRECT, mbx_pkg::MBX_CALL: begin
        en = 2;
        ovf = (op == mbx_pkg::MBX_CALL) && (stk.size() == 6);
        if (op == mbx_pkg::MBX_CALL && !ovf) stk.push_back(r);
        r = ad;
        pc_unk = 1'b0;
      end
      mbx_pkg::MBX_SUBROUTINE_EXIT, mbx_pkg::MBX_SUBROUTINE_EXIT_LOAD_ACC, mbx_pkg::MBX_INTERRUPT_EXIT: begin
        en = 2;
        if (stk.size() > 0) r = stk.pop_back();
        if (op == mbx_pkg::MBX_SUBROUTINE_EXIT_LOAD_ACC) e_acc = im;
        if (op == mbx_pkg::MBX_INTERRUPT_EXIT) e_gie = 1'b1;
      end
      mbx_pkg::MBX_SKIP_IF_ZERO: sk = (m == 8'h00);
      mbx_pkg::MBX_SKIP_ZERO_COPY_ACC: begin
        sk = (m == 8'h00);
        e_acc = m;
      end
      mbx_pkg::MBX_SKIP_BIT_CLEAR: sk = !m[bs];
      mbx_pkg::MBX_SKIP_BIT_SET: sk = m[bs];
      mbx_pkg::MBX_SKIP_INCREMENTED_ZERO, mbx_pkg::MBX_SKIP_DECREMENTED_ZERO: begin
        {we, mf} = 2'b11;
        wd = (op == mbx_pkg::MBX_SKIP_INCREMENTED_ZERO) ? m + 8'h01 : m - 8'h01;
        sk = (wd == 8'h00);
      end
      mbx_pkg::MBX_SKIP_INCREMENTED_ZERO_TO_ACC, mbx_pkg::MBX_SKIP_DECREMENTED_ZERO_TO_ACC: begin
        e_acc = (op == mbx_pkg::MBX_SKIP_INCREMENTED_ZERO_TO_ACC) ? m + 8'h01 : m - 8'h01;
        sk = (e_acc == 8'h00);
      end
      mbx_pkg::MBX_TABLE_FETCH_CURRENT_PAGE, mbx_pkg::MBX_TABLE_FETCH_LAST_PAGE: begin
        {we, mf, tw} = 3'b111;
        en = 2;
        wd = rw[7:0];
        if (op == mbx_pkg::MBX_TABLE_FETCH_LAST_PAGE) ra[PW-1:8] = '1;
      end
      mbx_pkg::MBX_CLEAR_BYTE, mbx_pkg::MBX_SET_BYTE, mbx_pkg::MBX_CLEAR_BIT, mbx_pkg::MBX_NIBBLE_EXCHANGE: begin
        {we, mf} = 2'b11;
        wd = (op == mbx_pkg::MBX_SET_BYTE) ? 8'hff : (op == mbx_pkg::MBX_CLEAR_BIT) ? m & ~(8'h01 << bs) :
             (op == mbx_pkg::MBX_NIBBLE_EXCHANGE) ? {m[3:0], m[7:4]} : 8'h00;
      end
      mbx_pkg::MBX_NIBBLE_EXCHANGE_TO_ACC: e_acc = {m[3:0], m[7:4]};
      mbx_pkg::MBX_WATCHDOG_CLEAR: {wc, pre1, pre2} = 3'b100;
      mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST: pre1 = 1'b1;
      mbx_pkg::MBX_WATCHDOG_PRECLEAR_SECOND: pre2 = 1'b1;
      mbx_pkg::MBX_ADD_WITH_CARRY, mbx_pkg::MBX_ADD_WITH_CARRY_TO_MEMORY, mbx_pkg::MBX_ADD,
      mbx_pkg::MBX_ADD_TO_MEMORY, mbx_pkg::MBX_ADD_IMMEDIATE: begin
        t = add8(e_acc, (op == mbx_pkg::MBX_ADD_IMMEDIATE) ? im : m,
                 (op == mbx_pkg::MBX_ADD_WITH_CARRY || op == mbx_pkg::MBX_ADD_WITH_CARRY_TO_MEMORY) & e_fl.c);
        e_fl = t[11:8];
        mf = (op == mbx_pkg::MBX_ADD_WITH_CARRY_TO_MEMORY || op == mbx_pkg::MBX_ADD_TO_MEMORY);
        {we, wd} = {mf, t[7:0]};
        if (!mf) e_acc = t[7:0];
      end
      mbx_pkg::MBX_BITWISE_AND, mbx_pkg::MBX_BITWISE_AND_TO_MEMORY, mbx_pkg::MBX_BITWISE_AND_IMMEDIATE: begin
        wd = e_acc & ((op == mbx_pkg::MBX_BITWISE_AND_IMMEDIATE) ? im : m);
        e_fl.z = (wd == 8'h00);
        mf = (op == mbx_pkg::MBX_BITWISE_AND_TO_MEMORY);
        we = mf;
        if (!mf) e_acc = wd;
      end
      mbx_pkg::MBX_HALT: {wc, hl} = 2'b11;
      default: ;
    endcase
    if (pre1 && pre2) begin
      {wc, pre1, pre2} = 3'b100;
    end
    if (wc) {e_to, e_pdf} = {1'b0, hl};
    if (sk) r = e_pc + 2'h2;
    en = en + sk + (pl && mf);
    if (pl && mf) pc_unk = 1'b1;
    e_pc = r;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= '{op, bs, im, ad, pl};
    mem_rdata <= m;
    rom_rdata <= rw;
    #1;
    chk(instr_ready, 1, "not ready");
    if (tw && !pu) chk(rom_addr, ra, "table address");
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    if (!pc_unk) chk(pc, e_pc, "pc");
    chk(acc, e_acc, "acc");
    chk(flags, e_fl, "flags");
    chk(skip_next, sk, "skip");
    chk(wr.mem_we, we, "mem write");
    if (we) chk(wr.mem_wdata, wd, "mem data");
    chk(wr.tbl_we, tw, "table write");
    if (tw) chk(table_high_byte, rw[13:8], "table high");
    chk(wdt_clear, wc, "wdt clear");
    chk(timeout_flag, e_to, "timeout");
    chk(power_down_flag, e_pdf, "power down");
    chk(halted, hl, "halted");
    chk(global_int_en, e_gie, "int enable");
    if (ovf) chk(stack_overflow, 1, "overflow");
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (hl && n == 4) wake <= 1'b1;
    end while (!instr_ready && n < 20);
    wake <= 1'b0;
    chk(n, 4 * en + hl, "cycle count");
  endtask

  task automatic rnd(input mbx_pkg::mbx_op_e op);
    if (pc_unk) op = mbx_pkg::MBX_JUMP_DIRECT;
    exec(op, 3'($urandom), 8'($urandom), PW'($urandom), ($urandom % 6) == 0,
         (($urandom % 3) == 0) ? 8'($urandom % 2) : 8'($urandom), 14'($urandom));
  endtask

  task automatic tmo();
    @(posedge clk);
    watchdog_timeout <= 1'b1;
    @(posedge clk);
    watchdog_timeout <= 1'b0;
    e_to = 1'b1;
  endtask

  initial begin
    #160000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(17));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // ----------------------------------------
    // corner cases
    // ----------------------------------------
    exec(mbx_pkg::MBX_ADD_IMMEDIATE, 0, 8'h7f, 0, 0, 8'h00, 0);
    exec(mbx_pkg::MBX_ADD_IMMEDIATE, 0, 8'h01, 0, 0, 8'h00, 0);
    exec(mbx_pkg::MBX_ADD, 0, 0, 0, 0, 8'h80, 0);
    exec(mbx_pkg::MBX_ADD_WITH_CARRY, 0, 0, 0, 0, 8'hff, 0);
    exec(mbx_pkg::MBX_SKIP_INCREMENTED_ZERO, 0, 0, 0, 1, 8'hff, 0);
    exec(mbx_pkg::MBX_SKIP_DECREMENTED_ZERO_TO_ACC, 0, 0, 0, 1, 8'h01, 0);
    exec(mbx_pkg::MBX_JUMP_DIRECT, 0, 0, 11'h7fe, 0, 8'h00, 0);
    exec(mbx_pkg::MBX_SKIP_BIT_SET, 3'h7, 0, 0, 0, 8'h80, 0);
    exec(mbx_pkg::MBX_SKIP_BIT_CLEAR, 3'h0, 0, 0, 0, 8'hfe, 0);
    tmo();
    exec(mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST, 0, 0, 0, 0, 0, 0);
    exec(mbx_pkg::MBX_WATCHDOG_PRECLEAR_SECOND, 0, 0, 0, 0, 0, 0);
    tmo();
    exec(mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST, 0, 0, 0, 0, 0, 0);
    exec(mbx_pkg::MBX_WATCHDOG_CLEAR, 0, 0, 0, 0, 0, 0);
    tmo();
    exec(mbx_pkg::MBX_WATCHDOG_PRECLEAR_SECOND, 0, 0, 0, 0, 0, 0);
    exec(mbx_pkg::MBX_WATCHDOG_PRECLEAR_FIRST, 0, 0, 0, 0, 0, 0);
    repeat (7) rnd(mbx_pkg::MBX_CALL);
    repeat (8) rnd(mbx_pkg::MBX_SUBROUTINE_EXIT);
    // ----------------------------------------
    // every operation (a jump stands in after a counter-low write), then random traffic
    // ----------------------------------------
    for (int i = 0; i < 33; i++) rnd(mbx_pkg::mbx_op_e'(i));
    repeat (300) rnd(mbx_pkg::mbx_op_e'($urandom % 33));
    finish_test();
  end
endmodule
`default_nettype wire
